/* design/tmr_map.svh */
// Register offsets, field positions and reset values of the timer channel.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_OFF_CTL0 12'h000
`define TMR_OFF_CTL1 12'h004
`define TMR_OFF_OPT0 12'h008
`define TMR_OFF_CCR0 12'h00C
`define TMR_OFF_CCR1 12'h010
`define TMR_OFF_CNT 12'h014
`define TMR_OFF_STAT 12'h018

`define TMR_CTL0_CE 0
`define TMR_CTL1_MD_LO 0
`define TMR_CTL1_MD_HI 2
`define TMR_CTL1_EST 3
`define TMR_CTL1_EEE 4
`define TMR_OPT0_CCS0 0
`define TMR_OPT0_CCS1 1
`define TMR_OPT0_OE0 2
`define TMR_OPT0_OE1 3
`define TMR_STAT_OVF 0

`define TMR_CNT_MAX 16'hFFFF
`define TMR_CNT_ZERO 16'h0000
`define TMR_CCR_RST 16'hFFFF
`define TMR_ONE 16'h0001

`endif

/* design/tmr_pkg.sv */
// Types shared by the timer channel.
// Assumes the offsets in tmr_map.svh.
`default_nettype none
package tmr_pkg;
	typedef enum logic [2:0] {
		TMR_MD_INTERVAL = 3'b000,
		TMR_MD_EVENT = 3'b001,
		TMR_MD_TRIG = 3'b010,
		TMR_MD_ONESHOT = 3'b011,
		TMR_MD_PWM = 3'b100,
		TMR_MD_FREE = 3'b101,
		TMR_MD_PWIDTH = 3'b110,
		TMR_MD_RSVD = 3'b111
	} tmr_mode_t;
endpackage : tmr_pkg
`default_nettype wire

/* design/tmr_timer16.sv */
// 16-bit timer channel: trigger pulse, one-shot, PWM, free-running modes.
// Assumes an APB master on pclk and asynchronous pins on trigger/capture.
// Behaviour
// - Trigger pulse mode: counter holds FFFFH until a trigger edge.
// - Trigger pulse mode: reg0 sets period, reg1 sets out1 duty.
// - Trigger and PWM modes: reload both buffers at reg0 match only when reg1 was written.
// - Trigger pulse mode: a new trigger clears and restarts the counter.
// - Software trigger bit acts as a trigger pin edge.
// - Out1 carries pulse; out0 toggles on reg0 match.
// - Trigger, one-shot and PWM modes never capture.
// - One-shot mode: counter holds FFFFH until a trigger, then counts.
// - One-shot: buffer1 match sets out1; buffer0 match clears, stops.
// - One-shot: triggers while counting are ignored.
// - One-shot: register writes reach buffers at once.
// - PWM mode: reg0 sets cycle, reg1 sets duty on out1.
// - PWM period is reg0 plus 1; duty reg1 over reg0 plus 1.
// - Free-running: counter runs on; select bits act only here.
// - Free-running compare writes apply at once; match raises event.
// - Free-running compare match toggles its enabled output.
// - Free-running capture stores the counter on a capture edge.
// - Trigger pulse mode: buffer1 match never clears the counter.
// - Free-running wrap sets overflow flag and event; write 0 clears.
//
// Added by the designer: the register addresses and the APB slave port.
`include "tmr_map.svh"
`default_nettype none
module tmr_timer16 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trigger_pin,
	input wire logic capture_input0,
	input wire logic capture_input1,
	output logic timer_out0_pin,
	output logic timer_out1_pin,
	output logic overflow_interrupt,
	output logic compare_match0,
	output logic compare_match1
);
	logic count_enable_bit_q;
	logic [2:0] mode_select_field_q;
	logic external_clock_select_bit_q;
	logic reg0_capture_select_q;
	logic reg1_capture_select_q;
	logic output_enable0_q;
	logic output_enable1_q;
	logic overflow_flag_q;
	logic soft_trig_q;
	logic [15:0] cap_cmp_reg0_q;
	logic [15:0] cap_cmp_reg1_q;
	logic [15:0] cmp_buf0_q;
	logic [15:0] cmp_buf1_q;
	logic reload_armed_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic running_q;
	logic running_d;
	logic out0_q;
	logic out1_q;
	logic ovf_pulse_q;
	logic [31:0] prdata_q;
	logic [2:0] trig_sync_q;
	logic [2:0] cap0_sync_q;
	logic [2:0] cap1_sync_q;
	logic trig_lvl_q;
	logic cap0_lvl_q;
	logic cap1_lvl_q;
	logic m0_q;
	logic m1_q;

	// Bus decode
	wire apb_access = psel && penable;
	wire apb_wr = apb_access && pwrite;
	wire apb_rd = apb_access && !pwrite;
	wire hit_ctl0 = paddr == `TMR_OFF_CTL0;
	wire hit_ctl1 = paddr == `TMR_OFF_CTL1;
	wire hit_opt0 = paddr == `TMR_OFF_OPT0;
	wire hit_ccr0 = paddr == `TMR_OFF_CCR0;
	wire hit_ccr1 = paddr == `TMR_OFF_CCR1;
	wire hit_cnt = paddr == `TMR_OFF_CNT;
	wire hit_stat = paddr == `TMR_OFF_STAT;
	wire hit_any = hit_ctl0 || hit_ctl1 || hit_opt0 || hit_ccr0 ||
		hit_ccr1 || hit_cnt || hit_stat;
	wire wr_ccr0 = apb_wr && hit_ccr0;
	wire wr_ccr1 = apb_wr && hit_ccr1;

	// Mode decode
	wire md_trig = mode_select_field_q == tmr_pkg::TMR_MD_TRIG;
	wire md_one = mode_select_field_q == tmr_pkg::TMR_MD_ONESHOT;
	wire md_pwm = mode_select_field_q == tmr_pkg::TMR_MD_PWM;
	wire md_free = mode_select_field_q == tmr_pkg::TMR_MD_FREE;
	wire md_reload = md_trig || md_pwm;
	wire md_pulse = md_trig || md_one || md_pwm;

	// Pin edges from agreeing synchroniser stages
	wire trig_edge = (trig_sync_q[2] == trig_sync_q[1]) &&
		(trig_sync_q[1] != trig_lvl_q);
	wire cap0_edge = (cap0_sync_q[2] == cap0_sync_q[1]) &&
		(cap0_sync_q[1] != cap0_lvl_q);
	wire cap1_edge = (cap1_sync_q[2] == cap1_sync_q[1]) &&
		(cap1_sync_q[1] != cap1_lvl_q);
	wire trigger = trig_edge || soft_trig_q;

	wire tick = count_enable_bit_q && running_q;
	wire match0 = tick && (count_q == cmp_buf0_q);
	wire match1 = tick && (count_q == cmp_buf1_q);
	// select bits only in free mode
	wire cap0_sel = md_free && reg0_capture_select_q;
	wire cap1_sel = md_free && reg1_capture_select_q;
	wire do_cap0 = count_enable_bit_q && cap0_sel && cap0_edge;
	wire do_cap1 = count_enable_bit_q && cap1_sel && cap1_edge;
	wire wrap = tick && md_free && (count_q == `TMR_CNT_MAX);
	wire ce_rise = apb_wr && hit_ctl0 && pwdata[`TMR_CTL0_CE] &&
		!count_enable_bit_q;
	// reload at reg0 match when armed
	wire do_reload = md_reload && match0 && reload_armed_q;
	wire anytime = !md_reload;

	// Counter next value
	always_comb begin
		count_d = count_q;
		running_d = running_q;
		if (!count_enable_bit_q) begin
			running_d = 1'b0;
			count_d = `TMR_CNT_ZERO;
			if (ce_rise && (md_trig || md_one)) begin
				count_d = `TMR_CNT_MAX;
			end
			if (ce_rise && !(md_trig || md_one)) begin
				running_d = 1'b1;
			end
		end else if (md_trig) begin
			if (trigger) begin
				count_d = `TMR_CNT_ZERO;
				running_d = 1'b1;
			end else if (match0) begin
				count_d = `TMR_CNT_ZERO;
			end else if (tick) begin
				count_d = count_q + `TMR_ONE;
			end
		end else if (md_one) begin
			if (!running_q && trigger) begin
				count_d = `TMR_CNT_ZERO;
				running_d = 1'b1;
			end else if (match0) begin
				count_d = `TMR_CNT_ZERO;
				running_d = 1'b0;
			end else if (tick) begin
				count_d = count_q + `TMR_ONE;
			end
		end else if (md_pwm && match0) begin
			count_d = `TMR_CNT_ZERO;
		end else if (tick) begin
			count_d = count_q + `TMR_ONE;
		end
	end

	// APB registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_enable_bit_q <= 1'b0;
			mode_select_field_q <= 3'h0;
			external_clock_select_bit_q <= 1'b0;
			reg0_capture_select_q <= 1'b0;
			reg1_capture_select_q <= 1'b0;
			output_enable0_q <= 1'b0;
			output_enable1_q <= 1'b0;
			soft_trig_q <= 1'b0;
		end else begin
			soft_trig_q <= 1'b0;
			if (apb_wr && hit_ctl0) begin
				count_enable_bit_q <= pwdata[`TMR_CTL0_CE];
			end
			if (apb_wr && hit_ctl1) begin
				mode_select_field_q <=
					pwdata[`TMR_CTL1_MD_HI:`TMR_CTL1_MD_LO];
				external_clock_select_bit_q <= pwdata[`TMR_CTL1_EEE];
				soft_trig_q <= pwdata[`TMR_CTL1_EST] &&
					count_enable_bit_q;
			end
			if (apb_wr && hit_opt0) begin
				reg0_capture_select_q <= pwdata[`TMR_OPT0_CCS0];
				reg1_capture_select_q <= pwdata[`TMR_OPT0_CCS1];
				output_enable0_q <= pwdata[`TMR_OPT0_OE0];
				output_enable1_q <= pwdata[`TMR_OPT0_OE1];
			end
		end
	end

	// Compare registers, buffers and capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_cmp_reg0_q <= `TMR_CCR_RST;
			cap_cmp_reg1_q <= `TMR_CCR_RST;
			cmp_buf0_q <= `TMR_CCR_RST;
			cmp_buf1_q <= `TMR_CCR_RST;
			reload_armed_q <= 1'b0;
		end else begin
			if (do_cap0) begin
				cap_cmp_reg0_q <= count_q;
			end else if (wr_ccr0) begin
				cap_cmp_reg0_q <= pwdata[15:0];
			end
			if (do_cap1) begin
				cap_cmp_reg1_q <= count_q;
			end else if (wr_ccr1) begin
				cap_cmp_reg1_q <= pwdata[15:0];
			end
			if (anytime || !count_enable_bit_q) begin
				cmp_buf0_q <= cap_cmp_reg0_q;
				cmp_buf1_q <= cap_cmp_reg1_q;
			end else if (do_reload) begin
				cmp_buf0_q <= cap_cmp_reg0_q;
				cmp_buf1_q <= cap_cmp_reg1_q;
			end
			// reg1 write arms; set wins over reload clear
			if (wr_ccr1 && md_reload) begin
				reload_armed_q <= 1'b1;
			end else if (do_reload || !count_enable_bit_q) begin
				reload_armed_q <= 1'b0;
			end
		end
	end

	// Counter, outputs and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= `TMR_CNT_ZERO;
			running_q <= 1'b0;
			out0_q <= 1'b0;
			out1_q <= 1'b0;
			overflow_flag_q <= 1'b0;
			ovf_pulse_q <= 1'b0;
			m0_q <= 1'b0;
			m1_q <= 1'b0;
		end else begin
			count_q <= count_d;
			running_q <= running_d;
			ovf_pulse_q <= wrap;
			m0_q <= match0 && !cap0_sel;
			m1_q <= match1 && !cap1_sel;
			if (wrap) begin
				overflow_flag_q <= 1'b1;
			end else if (apb_wr && hit_stat &&
				!pwdata[`TMR_STAT_OVF]) begin
				overflow_flag_q <= 1'b0;
			end
			if (!count_enable_bit_q) begin
				out0_q <= 1'b0;
				out1_q <= 1'b0;
			end else begin
				if (match0 && output_enable0_q && !cap0_sel) begin
					out0_q <= !out0_q;
				end
				if (md_pulse && output_enable1_q) begin
					if (match0) begin
						out1_q <= 1'b0;
					end else if (match1 || (md_reload &&
						count_q == `TMR_CNT_ZERO && tick &&
						cmp_buf1_q != `TMR_CNT_ZERO)) begin
						out1_q <= !md_one ? !match1 : 1'b1;
					end
				end else if (md_free && output_enable1_q &&
					match1 && !cap1_sel) begin
					out1_q <= !out1_q;
				end
			end
		end
	end

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sync_q <= 3'h0;
			cap0_sync_q <= 3'h0;
			cap1_sync_q <= 3'h0;
			trig_lvl_q <= 1'b0;
			cap0_lvl_q <= 1'b0;
			cap1_lvl_q <= 1'b0;
		end else begin
			trig_sync_q <= {trig_sync_q[1:0], ext_trigger_pin};
			cap0_sync_q <= {cap0_sync_q[1:0], capture_input0};
			cap1_sync_q <= {cap1_sync_q[1:0], capture_input1};
			if (trig_sync_q[2] == trig_sync_q[1]) begin
				trig_lvl_q <= trig_sync_q[1];
			end
			if (cap0_sync_q[2] == cap0_sync_q[1]) begin
				cap0_lvl_q <= cap0_sync_q[1];
			end
			if (cap1_sync_q[2] == cap1_sync_q[1]) begin
				cap1_lvl_q <= cap1_sync_q[1];
			end
		end
	end

	// Read data
	wire [31:0] rd_mux =
		hit_ctl0 ? {31'h0, count_enable_bit_q} :
		hit_ctl1 ? {27'h0, external_clock_select_bit_q, 1'b0,
			mode_select_field_q} :
		hit_opt0 ? {28'h0, output_enable1_q, output_enable0_q,
			reg1_capture_select_q, reg0_capture_select_q} :
		hit_ccr0 ? {16'h0, cap_cmp_reg0_q} :
		hit_ccr1 ? {16'h0, cap_cmp_reg1_q} :
		hit_cnt ? {16'h0, count_q} :
		hit_stat ? {31'h0, overflow_flag_q} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata = apb_rd ? prdata_q : 32'h0;
	assign pready = 1'b1;
	assign pslverr = apb_access && !hit_any;
	assign timer_out0_pin = out0_q;
	assign timer_out1_pin = out1_q;
	assign overflow_interrupt = ovf_pulse_q;
	assign compare_match0 = m0_q;
	assign compare_match1 = m1_q;
endmodule : tmr_timer16
`default_nettype wire

/* tb/tmr_timer16_checker.sv */
// Port checker for the timer channel.
// Assumes binding onto tmr_timer16.
`default_nettype none
module tmr_timer16_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer_out0_pin,
	input wire logic overflow_interrupt,
	input wire logic compare_match0,
	input wire logic compare_match1
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_idle; !(psel && penable) |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("prdata not zero");
	property p_refd; pslverr |-> prdata == 32'h0; endproperty
	a_refd: assert property (p_refd) else $error("refused read data");
	property p_cm0; compare_match0 |=> !compare_match0; endproperty
	a_cm0: assert property (p_cm0) else $error("match0 too long");
	property p_cm1; compare_match1 |=> !compare_match1; endproperty
	a_cm1: assert property (p_cm1) else $error("match1 too long");
	property p_ovf; overflow_interrupt |=> !overflow_interrupt [*8];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow repeat");
	property p_t0;
		$rose(timer_out0_pin) |-> compare_match0 || $past(compare_match0);
	endproperty
	a_t0: assert property (p_t0) else $error("out0 rose unmatched");
endmodule : tmr_timer16_checker
bind tmr_timer16 tmr_timer16_checker u_chk (.pclk, .presetn, .psel,
	.penable, .prdata, .pready, .pslverr, .timer_out0_pin,
	.overflow_interrupt, .compare_match0, .compare_match1);
`default_nettype wire

/* tb/tmr_pins_model.sv */
// Trigger and capture sources at the pin side.
// Assumes tasks are called right after a rising pclk edge.
`default_nettype none
module tmr_pins_model (
	input wire logic pclk,
	output logic ext_trigger_pin,
	output logic capture_input0,
	output logic capture_input1
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ext_trigger_pin = 1'h0;
		capture_input0 = 1'h0;
		capture_input1 = 1'h0;
	end
	task automatic kick_trig;
		ext_trigger_pin <= !ext_trigger_pin;
		@(posedge pclk);
	endtask : kick_trig
	task automatic kick_cap0;
		capture_input0 <= !capture_input0;
		@(posedge pclk);
	endtask : kick_cap0
	task automatic kick_cap1;
		capture_input1 <= !capture_input1;
		@(posedge pclk);
	endtask : kick_cap1
endmodule : tmr_pins_model
`default_nettype wire

/* tb/tmr_timer16_tb_top.sv */
// Self-checking bench for the timer channel.
// Assumes tmr_map.svh offsets and the pin model.
`include "tmr_map.svh"
`default_nettype none
module tmr_timer16_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ext_trigger_pin, capture_input0, capture_input1;
	logic timer_out0_pin, timer_out1_pin, overflow_interrupt;
	logic compare_match0, compare_match1;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int h1, h0, hv, hc;
	tmr_timer16 DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ext_trigger_pin,
		.capture_input0, .capture_input1, .timer_out0_pin,
		.timer_out1_pin, .overflow_interrupt, .compare_match0,
		.compare_match1);
	tmr_pins_model u_pins (.pclk, .ext_trigger_pin, .capture_input0,
		.capture_input1);
	initial begin
		pclk = 1'h0;
		forever #50 pclk = !pclk;
	end
	task automatic end_sim;
		$display("mismatches %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rdc(input string n, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, e, rd);
	endtask : rdc
	task automatic rng(input string n, input logic [11:0] a, input int lo, hi);
		apb(1'h0, a, 32'h0);
		chk(n, 32'h1, {31'h0, rd >= lo && rd < hi});
	endtask : rng
	task automatic meas(input int n);
		{h1, h0, hv, hc} = '0;
		repeat (n) begin
			@(posedge pclk);
			h1 += timer_out1_pin;
			h0 += timer_out0_pin;
			hv += overflow_interrupt;
			hc += compare_match0;
		end
	endtask : meas
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rdc("ccr0_rst", `TMR_OFF_CCR0, 32'h0000FFFF);
		apb(1'h0, 12'hFFC, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("reset test done");
		wr(`TMR_OFF_OPT0, 32'h0000000C);
		wr(`TMR_OFF_CCR0, 32'h00000040);
		wr(`TMR_OFF_CCR1, 32'h00000020);
		wr(`TMR_OFF_CTL1, 32'h00000002);
		wr(`TMR_OFF_CTL0, 32'h00000001);
		rdc("trg_hold", `TMR_OFF_CNT, 32'h0000FFFF);
		u_pins.kick_trig();
		repeat (40) @(posedge pclk);
		rng("trg_pass1", `TMR_OFF_CNT, 32'h21, 32'h30);
		wr(`TMR_OFF_CTL1, 32'h0000000A);
		rng("sw_retrig", `TMR_OFF_CNT, 0, 8);
		repeat (20) @(posedge pclk);
		u_pins.kick_trig();
		repeat (8) @(posedge pclk);
		rng("pin_retrig", `TMR_OFF_CNT, 0, 12);
		meas(65);
		chk("trg_duty", 32'd32, h1);
		chk("trg_period", 32'd1, hc);
		wr(`TMR_OFF_CTL0, 32'h00000000);
		rdc("stopped", `TMR_OFF_CNT, 32'h00000000);
		$display("trigger test done");
		wr(`TMR_OFF_CTL1, 32'h00000003);
		wr(`TMR_OFF_CCR0, 32'h00000030);
		wr(`TMR_OFF_CCR1, 32'h00000010);
		wr(`TMR_OFF_CTL0, 32'h00000001);
		rdc("os_hold", `TMR_OFF_CNT, 32'h0000FFFF);
		wr(`TMR_OFF_CTL1, 32'h0000000B);
		repeat (20) @(posedge pclk);
		u_pins.kick_trig();
		repeat (6) @(posedge pclk);
		rng("os_ignore", `TMR_OFF_CNT, 32'h14, 32'h30);
		chk("os_out1_hi", 32'h1, {31'h0, timer_out1_pin});
		repeat (40) @(posedge pclk);
		rdc("os_stop", `TMR_OFF_CNT, 32'h00000000);
		chk("os_out1_lo", 32'h0, {31'h0, timer_out1_pin});
		$display("one-shot test done");
		wr(`TMR_OFF_CTL0, 32'h00000000);
		wr(`TMR_OFF_CTL1, 32'h00000004);
		wr(`TMR_OFF_CCR0, 32'h00000009);
		wr(`TMR_OFF_CCR1, 32'h00000004);
		wr(`TMR_OFF_CTL0, 32'h00000001);
		meas(20);
		meas(100);
		chk("pwm_duty", 32'd40, h1);
		chk("pwm_out0", 32'd50, h0);
		wr(`TMR_OFF_CCR0, 32'h00000013);
		meas(30);
		meas(100);
		chk("pwm_norel", 32'd40, h1);
		wr(`TMR_OFF_CCR1, 32'h00000004);
		meas(40);
		meas(100);
		chk("pwm_rel", 32'd20, h1);
		wr(`TMR_OFF_OPT0, 32'h0000000D);
		u_pins.kick_cap0();
		repeat (6) @(posedge pclk);
		rdc("no_cap", `TMR_OFF_CCR0, 32'h00000013);
		$display("pwm test done");
		wr(`TMR_OFF_CTL0, 32'h00000000);
		wr(`TMR_OFF_CTL1, 32'h00000005);
		wr(`TMR_OFF_OPT0, 32'h00000006);
		wr(`TMR_OFF_CCR0, 32'h00000100);
		wr(`TMR_OFF_CTL0, 32'h00000001);
		repeat (100) @(posedge pclk);
		u_pins.kick_cap1();
		repeat (10) @(posedge pclk);
		rng("capture", `TMR_OFF_CCR1, 32'h64, 32'h70);
		meas(65600);
		chk("ovf_pulse", 32'd1, hv);
		chk("cmp0_pulse", 32'd1, hc);
		chk("fr_out0", 32'h1, {31'h0, timer_out0_pin});
		rdc("ovf_flag", `TMR_OFF_STAT, 32'h00000001);
		wr(`TMR_OFF_STAT, 32'h00000000);
		rdc("ovf_clr", `TMR_OFF_STAT, 32'h00000000);
		$display("free-run test done");
		end_sim();
	end
endmodule : tmr_timer16_tb_top
`default_nettype wire
